// ===== ptf_defs.vh
`ifndef PTF_DEFS_VH
`define PTF_DEFS_VH
// =====================================================
// octet codes
`define PTF_FLAG 8'h7e
`define PTF_ESC 8'h7d
`define PTF_XOR 8'h20
// =====================================================
// fifo geometry
`define PTF_AW 8
`define PTF_PW 9
`define PTF_DEPTH 9'h100
`define PTF_MW 10
// =====================================================
// register word indexes (byte address = 4 * index)
`define PTF_REG_CTRL 6'h00
`define PTF_REG_WMARK 6'h01
`define PTF_REG_STAT 6'h02
`define PTF_REG_CNT 6'h03
// =====================================================
// control fields and reset values
`define PTF_B_FCS 0
`define PTF_B_C32 1
`define PTF_B_ERR 2
`define PTF_B_SCR 3
`define PTF_F_IPG 15:8
`define PTF_CTRL_RST 32'h0000_0009
`define PTF_F_HI 8:0
`define PTF_F_LO 24:16
`define PTF_HI_RST 9'h0e0
`define PTF_LO_RST 9'h080
// =====================================================
// status fields
`define PTF_F_LVL 8:0
`define PTF_B_OVR 16
`define PTF_B_ABT 17
`define PTF_B_TPA 18
// =====================================================
// check value
`define PTF_P16 16'h1021
`define PTF_P32 32'h04c1_1db7
`define PTF_INIT16 32'h0000_ffff
`define PTF_INIT32 32'hffff_ffff
// =====================================================
// scrambler
`define PTF_SCR_LEN 43
`define PTF_SCR_ONES 43'h7ff_ffff_ffff
`endif

// ===== ptf_fifo_mem.v
`include "ptf_defs.vh"
module ptf_fifo_mem (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_we,
  input wire [`PTF_AW-1:0] i_waddr,
  input wire [`PTF_MW-1:0] i_wdata,
  input wire [`PTF_AW-1:0] i_raddr,
  output reg [`PTF_MW-1:0] o_rdata
);
  // =====================================================
  // 256 octets, each with start and end markers
  reg [`PTF_MW-1:0] mem [0:255];

  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // read data always follows the read pointer, one cycle late
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= {`PTF_MW{1'b0}};
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule

// ===== ptf_scrambler.v
`include "ptf_defs.vh"
module ptf_scrambler (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_step,
  input wire i_on,
  input wire [7:0] i_byte,
  output reg [7:0] o_byte
);
  // =====================================================
  // self-synchronous x^43+1, msb of each octet first
  reg [`PTF_SCR_LEN-1:0] st_ff;
  reg [`PTF_SCR_LEN-1:0] nxt_st;
  reg [7:0] scr;
  integer i;

  always @* begin
    nxt_st = st_ff;
    scr = 8'h00;
    for (i = 7; i >= 0; i = i - 1) begin
      scr[i] = i_byte[i] ^ nxt_st[`PTF_SCR_LEN-1];
      nxt_st = {nxt_st[`PTF_SCR_LEN-2:0], scr[i]};
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= `PTF_SCR_ONES;
      o_byte <= `PTF_FLAG;
    end else if (i_step) begin
      // state keeps running while bypassed so re-enabling needs no reload
      st_ff <= nxt_st;
      o_byte <= i_on ? scr : i_byte;
    end
  end
endmodule

// ===== ptf_tx_framer.v
// Functional notes
// - send flag octets 7e whenever no packet data is ready to go
// - transmit fifo holds up to 256 octets, any number of packets
// - 16-bit words in on write clock, octets out on line clock
// - pointers give fill level driving overrun, underrun, aborts, flags, available
// - overrun drops octets but never aborts the packet being written
// - fifo empty mid-packet aborts with 7d then 7e
// - after abort, remaining packet octets are read, dropped, replaced by flags
// - after abort, data resumes only at a start-of-packet marker
// - programmable count of flags is inserted between frames
// - check value over whole frame before stuffing; 16 or 32 bit selectable
// - 16-bit check uses x^16+x^12+x^5+1, two octets
// - 32-bit check uses the standard 32-bit generator, four octets
// - check value goes out highest-degree coefficient first
// - check octets follow last data octet, before closing flag
// - sent check value is the inverse of the final crc register
// - check value generation and insertion can be switched off
// - error insertion inverts the check value before sending
// - 7e and 7d in frame become 7d then octet xor 20
// - optional x^43+1 scrambling of whole stream, flags included
// - scrambler state is all ones after reset
// - output pauses in overhead positions; no overhead octet is written
//
// Design decisions made here: the Wishbone register port and the register offsets.
`include "ptf_defs.vh"
module ptf_tx_framer (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire i_system_write_clock,
  input wire i_tx_enable,
  input wire [15:0] i_tx_data,
  input wire i_tx_sop,
  input wire i_tx_eop,
  input wire i_tx_mod,
  output reg o_transmit_packet_available,
  input wire i_line_side_clock,
  input wire i_overhead_gap,
  output wire [7:0] o_line_data,
  output reg o_line_valid
);
  // =====================================================
  // states
  localparam S_IDLE = 3'h0;
  localparam S_DATA = 3'h1;
  localparam S_FCS = 3'h2;
  localparam S_ABT = 3'h3;
  localparam S_DISC = 3'h4;

  // =====================================================
  // functions
  function [31:0] crc_step;
    input [31:0] c;
    input [7:0] d;
    input m32;
    integer i;
    reg [31:0] r;
    reg fb;
    begin
      r = c;
      for (i = 7; i >= 0; i = i - 1) begin
        if (m32) begin
          fb = r[31] ^ d[i];
          r = {r[30:0], 1'b0};
          if (fb) r = r ^ `PTF_P32;
        end else begin
          fb = r[15] ^ d[i];
          r = {16'h0000, r[14:0], 1'b0};
          if (fb) r = r ^ {16'h0000, `PTF_P16};
        end
      end
      crc_step = r;
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) merge[k*8 +: 8] = nw[k*8 +: 8];
      end
    end
  endfunction

  // =====================================================
  // pin synchronisers; stage 3 holds the sample taken just before an edge
  reg [2:0] wclk_ff;
  reg [19:0] w1_ff;
  reg [19:0] w2_ff;
  reg [19:0] w3_ff;
  reg [2:0] lclk_ff;
  reg g1_ff;
  reg g2_ff;
  wire sys_edge = wclk_ff[1] & ~wclk_ff[2];
  wire line_edge = lclk_ff[1] & ~lclk_ff[2];
  wire slot = line_edge & ~g2_ff;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wclk_ff <= 3'h0;
      w1_ff <= 20'h00000;
      w2_ff <= 20'h00000;
      w3_ff <= 20'h00000;
      lclk_ff <= 3'h0;
      g1_ff <= 1'b0;
      g2_ff <= 1'b0;
    end else begin
      wclk_ff <= {wclk_ff[1:0], i_system_write_clock};
      w1_ff <= {i_tx_enable, i_tx_sop, i_tx_eop, i_tx_mod, i_tx_data};
      w2_ff <= w1_ff;
      w3_ff <= w2_ff;
      lclk_ff <= {lclk_ff[1:0], i_line_side_clock};
      g1_ff <= i_overhead_gap;
      g2_ff <= g1_ff;
    end
  end

  // =====================================================
  // registers
  reg [31:0] ctrl_ff;
  reg [31:0] wmark_ff;
  reg ovr_ff;
  reg abt_ff;
  reg [15:0] frm_cnt_ff;
  reg [15:0] abt_cnt_ff;
  wire fcs_en = ctrl_ff[`PTF_B_FCS];
  wire m32 = ctrl_ff[`PTF_B_C32];
  wire err_ins = ctrl_ff[`PTF_B_ERR];
  wire scr_en = ctrl_ff[`PTF_B_SCR];
  wire [7:0] ipg = ctrl_ff[`PTF_F_IPG];

  // =====================================================
  // fifo pointers
  reg [`PTF_PW-1:0] wr_ptr_ff;
  reg [`PTF_PW-1:0] wr_seen_ff;
  reg [`PTF_PW-1:0] rd_ptr_ff;
  reg [1:0] wph_ff;
  reg [19:0] hold_ff;
  wire [`PTF_MW-1:0] head;
  wire [`PTF_PW-1:0] lvl = wr_ptr_ff - rd_ptr_ff;
  // read side trusts only pointers whose octets have reached the ram
  wire avail = (wr_seen_ff != rd_ptr_ff);
  wire full = (lvl == `PTF_DEPTH);
  wire wr_req = (wph_ff != 2'h0);
  wire do_wr = wr_req & ~full;
  wire ovr_set = wr_req & full;
  wire last_hi = hold_ff[17] & hold_ff[16];
  wire [`PTF_MW-1:0] wbyte = (wph_ff == 2'h1) ?
    {hold_ff[18], last_hi, hold_ff[15:8]} : {1'b0, hold_ff[17], hold_ff[7:0]};
  wire head_sop = head[9];
  wire head_eop = head[8];
  reg rd_step;

  // =====================================================
  // write side: one word per write-clock edge, high octet first
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wph_ff <= 2'h0;
      hold_ff <= 20'h00000;
      wr_ptr_ff <= {`PTF_PW{1'b0}};
      wr_seen_ff <= {`PTF_PW{1'b0}};
      rd_ptr_ff <= {`PTF_PW{1'b0}};
    end else begin
      wr_seen_ff <= wr_ptr_ff;
      if (rd_step) rd_ptr_ff <= rd_ptr_ff + 9'h001;
      // an overrun drops octets and sets the overrun flag; the frame closes normally only if its end-marker octet was stored
      if (do_wr) wr_ptr_ff <= wr_ptr_ff + 9'h001;
      case (wph_ff)
        2'h0: begin
          if (sys_edge & w3_ff[19]) begin
            hold_ff <= w3_ff;
            wph_ff <= 2'h1;
          end
        end
        2'h1: wph_ff <= last_hi ? 2'h0 : 2'h2;
        default: wph_ff <= 2'h0;
      endcase
    end
  end

  ptf_fifo_mem u_mem (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(do_wr),
    .i_waddr(wr_ptr_ff[`PTF_AW-1:0]),
    .i_wdata(wbyte),
    .i_raddr(rd_ptr_ff[`PTF_AW-1:0]),
    .o_rdata(head)
  );

  // =====================================================
  // packet available with watermark hysteresis
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_transmit_packet_available <= 1'b1;
    end else if (lvl >= wmark_ff[`PTF_F_HI]) begin
      o_transmit_packet_available <= 1'b0;
    end else if (lvl <= wmark_ff[`PTF_F_LO]) begin
      o_transmit_packet_available <= 1'b1;
    end
  end

  // =====================================================
  // line side frame generator, one step per line octet slot
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [8:0] gap_ff;
  reg [8:0] nxt_gap;
  reg [7:0] pend_ff;
  reg [7:0] nxt_pend;
  reg pend_v_ff;
  reg nxt_pend_v;
  reg [31:0] crc_ff;
  reg [31:0] nxt_crc;
  reg [1:0] idx_ff;
  reg [1:0] nxt_idx;
  reg [7:0] ob;
  reg [7:0] raw;
  reg stuff;
  reg take;
  reg abort_ev;
  reg frame_end;
  wire [31:0] fcs = err_ins ? crc_ff : ~crc_ff;
  wire [7:0] fcs_byte = fcs[idx_ff*8 +: 8];

  always @* begin
    nxt_state = state_ff;
    nxt_gap = gap_ff;
    nxt_pend = pend_ff;
    nxt_pend_v = pend_v_ff;
    nxt_crc = crc_ff;
    nxt_idx = idx_ff;
    rd_step = 1'b0;
    ob = `PTF_FLAG;
    raw = 8'h00;
    stuff = 1'b0;
    take = 1'b0;
    abort_ev = 1'b0;
    frame_end = 1'b0;
    if (slot) begin
      if (pend_v_ff) begin
        ob = pend_ff;
        nxt_pend_v = 1'b0;
      end else begin
        case (state_ff)
          S_IDLE: begin
            if (gap_ff != 9'h000) begin
              nxt_gap = gap_ff - 9'h001;
            end else if (avail) begin
              rd_step = 1'b1;
              take = head_sop;
            end
          end
          S_DATA: begin
            if (avail) begin
              rd_step = 1'b1;
              take = 1'b1;
            end else begin
              ob = `PTF_ESC;
              nxt_state = S_ABT;
              abort_ev = 1'b1;
            end
          end
          S_FCS: begin
            raw = fcs_byte;
            stuff = 1'b1;
            nxt_idx = idx_ff - 2'h1;
            if (idx_ff == 2'h0) begin
              nxt_state = S_IDLE;
              nxt_gap = {1'b0, ipg} + 9'h001;
              frame_end = 1'b1;
            end
          end
          S_ABT: nxt_state = S_DISC;
          S_DISC: begin
            if (avail) begin
              if (head_sop) begin
                nxt_state = S_IDLE;
                nxt_gap = {1'b0, ipg};
              end else begin
                rd_step = 1'b1;
              end
            end
          end
          default: nxt_state = S_IDLE;
        endcase
        if (take) begin
          raw = head[7:0];
          stuff = 1'b1;
          // crc restarts at each start marker, so a new frame never inherits
          nxt_crc = crc_step(head_sop ? (m32 ? `PTF_INIT32 : `PTF_INIT16) : crc_ff,
            head[7:0], m32);
          nxt_state = S_DATA;
          if (head_eop) begin
            if (fcs_en) begin
              nxt_state = S_FCS;
              nxt_idx = m32 ? 2'h3 : 2'h1;
            end else begin
              nxt_state = S_IDLE;
              nxt_gap = {1'b0, ipg} + 9'h001;
              frame_end = 1'b1;
            end
          end
        end
        if (stuff) begin
          if ((raw == `PTF_FLAG) || (raw == `PTF_ESC)) begin
            ob = `PTF_ESC;
            nxt_pend = raw ^ `PTF_XOR;
            nxt_pend_v = 1'b1;
          end else begin
            ob = raw;
          end
        end
      end
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= S_IDLE;
      gap_ff <= 9'h000;
      pend_ff <= 8'h00;
      pend_v_ff <= 1'b0;
      crc_ff <= `PTF_INIT32;
      idx_ff <= 2'h0;
      o_line_valid <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      gap_ff <= nxt_gap;
      pend_ff <= nxt_pend;
      pend_v_ff <= nxt_pend_v;
      crc_ff <= nxt_crc;
      idx_ff <= nxt_idx;
      o_line_valid <= slot;
    end
  end

  ptf_scrambler u_scr (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_step(slot),
    .i_on(scr_en),
    .i_byte(ob),
    .o_byte(o_line_data)
  );

  // =====================================================
  // wishbone slave, answers one cycle after the request
  wire wb_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire [5:0] widx = i_wb_adr[7:2];
  wire wr_en = wb_hit & i_wb_we;
  wire clr_ovr = wr_en & (widx == `PTF_REG_STAT) & i_wb_sel[2] & i_wb_dat[`PTF_B_OVR];
  wire clr_abt = wr_en & (widx == `PTF_REG_STAT) & i_wb_sel[2] & i_wb_dat[`PTF_B_ABT];
  reg [31:0] rd_mux;

  always @* begin
    case (widx)
      `PTF_REG_CTRL: rd_mux = ctrl_ff;
      `PTF_REG_WMARK: rd_mux = wmark_ff;
      `PTF_REG_STAT: rd_mux = {13'h0000, o_transmit_packet_available, abt_ff, ovr_ff,
        7'h00, lvl};
      `PTF_REG_CNT: rd_mux = {abt_cnt_ff, frm_cnt_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      ctrl_ff <= `PTF_CTRL_RST;
      wmark_ff <= {7'h00, `PTF_LO_RST, 7'h00, `PTF_HI_RST};
      ovr_ff <= 1'b0;
      abt_ff <= 1'b0;
      frm_cnt_ff <= 16'h0000;
      abt_cnt_ff <= 16'h0000;
    end else begin
      o_wb_ack <= wb_hit;
      if (wb_hit & ~i_wb_we) o_wb_dat <= rd_mux;
      if (wr_en & (widx == `PTF_REG_CTRL)) begin
        ctrl_ff <= merge(ctrl_ff, i_wb_dat, i_wb_sel) & 32'h0000_ff0f;
      end
      if (wr_en & (widx == `PTF_REG_WMARK)) begin
        wmark_ff <= merge(wmark_ff, i_wb_dat, i_wb_sel) & 32'h01ff_01ff;
      end
      // a new event in the clearing cycle keeps its flag set
      ovr_ff <= ovr_set | (ovr_ff & ~clr_ovr);
      abt_ff <= abort_ev | (abt_ff & ~clr_abt);
      if (frame_end) frm_cnt_ff <= frm_cnt_ff + 16'h0001;
      if (abort_ev) abt_cnt_ff <= abt_cnt_ff + 16'h0001;
    end
  end
endmodule

// ===== ptf_tx_framer_assertions.sv
module ptf_tx_framer_chk (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  input wire o_transmit_packet_available,
  input wire i_line_side_clock,
  input wire i_overhead_gap,
  input wire [7:0] o_line_data,
  input wire o_line_valid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  // =====================================================
  // register bus
  chk_ack_latency: assert property (req |=> o_wb_ack) else $error("ack late");
  chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  chk_ack_cause: assert property (o_wb_ack |-> $past(req)) else $error("ack without request");
  chk_rd_unmapped: assert property ((req && !i_wb_we && i_wb_adr[7:4] != 4'h0)
    |=> o_wb_dat == 32'h0) else $error("unmapped read not zero");
  // =====================================================
  // line side
  chk_valid_single: assert property (o_line_valid |=> !o_line_valid)
    else $error("valid too long");
  chk_data_hold: assert property (!o_line_valid |-> $stable(o_line_data))
    else $error("octet changed off slot");
  chk_gap_pause: assert property (i_overhead_gap [*6] |-> !o_line_valid)
    else $error("octet in overhead");
  // idle slots still carry an octet, a fill flag
  chk_slot_answer: assert property (($rose(i_line_side_clock) && !i_overhead_gap)
    |-> ##[1:6] (o_line_valid || i_overhead_gap)) else $error("slot without octet");
  chk_avail_reset: assert property ($rose(i_rst_n) |-> o_transmit_packet_available)
    else $error("no room after reset");
  cover property (o_line_valid);
  cover property (i_overhead_gap [*6]);
  cover property (req && i_wb_we);
endmodule
bind ptf_tx_framer ptf_tx_framer_chk u_ptf_tx_framer_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .o_transmit_packet_available(o_transmit_packet_available),
  .i_line_side_clock(i_line_side_clock), .i_overhead_gap(i_overhead_gap),
  .o_line_data(o_line_data), .o_line_valid(o_line_valid));

// ===== ptf_pkt_src.sv
module ptf_pkt_src (
  input wire i_clk,
  output logic o_wclk,
  output logic o_en,
  output logic [15:0] o_dat,
  output logic o_sop,
  output logic o_eop,
  output logic o_mod
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_wclk = 1'b0;
    o_en = 1'b0;
    o_dat = 16'h0;
    o_sop = 1'b0;
    o_eop = 1'b0;
    o_mod = 1'b0;
  end
  // clock stands still between words; released data is inverted so stale values never match
  task automatic send(input [15:0] d, input s, input e, input m);
    begin
      @(posedge i_clk);
      o_en <= 1'b1;
      o_dat <= d;
      o_sop <= s;
      o_eop <= e;
      o_mod <= m;
      repeat (4) @(posedge i_clk);
      o_wclk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_wclk <= 1'b0;
      o_en <= 1'b0;
      o_dat <= ~d;
    end
  endtask
endmodule

// ===== ptf_tx_framer_tb.sv
module ptf_tx_framer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_rst_n = 0, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
  logic [7:0] i_wb_adr = 8'h0, o_line_data, rnd = 8'h45, gr = 8'h45, x;
  logic [3:0] i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, q;
  logic o_wb_ack, o_transmit_packet_available, o_line_valid;
  // son: scrambler enable as the bench last wrote it
  logic i_line_side_clock = 0, i_overhead_gap = 0, run = 0, son = 1;
  logic [2:0] lc = 3'h0;
  logic [42:0] ds;
  wire wclk, en, sop, eop, md;
  wire [15:0] dat;
  logic [7:0] expq[$], b[$];
  integer failures = 0, checks = 0, gap = 0, lastgap = 0, i, k;
  logic [31:0] modes[6] = '{32'h09, 32'h0b, 32'h0d, 32'h08, 32'h030f, 32'h01};
  always #20 i_clk = ~i_clk;
  ptf_pkt_src u_ptf_pkt_src (.i_clk(i_clk), .o_wclk(wclk), .o_en(en), .o_dat(dat),
    .o_sop(sop), .o_eop(eop), .o_mod(md));
  ptf_tx_framer u_ptf_tx_framer (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_system_write_clock(wclk), .i_tx_enable(en), .i_tx_data(dat), .i_tx_sop(sop),
    .i_tx_eop(eop), .i_tx_mod(md), .o_transmit_packet_available(o_transmit_packet_available),
    .i_line_side_clock(i_line_side_clock), .i_overhead_gap(i_overhead_gap),
    .o_line_data(o_line_data), .o_line_valid(o_line_valid));
  // =====================================================
  // helpers
  function automatic [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic [31:0] crcb(input [31:0] c, input [7:0] d, input m);
    integer j;
    logic f;
    begin
      for (j = 7; j >= 0; j--) begin
        f = d[j] ^ (m ? c[31] : c[15]);
        c = c << 1;
        if (f) c = c ^ (m ? 32'h04c1_1db7 : 32'h0000_1021);
      end
      crcb = c;
    end
  endfunction
  task chk(input [31:0] s, input [31:0] e);
    begin
      checks++;
      if (s !== e) begin
        failures++;
        $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task automatic wb(input [7:0] a, input w, input [31:0] d, output [31:0] r);
    int n;
    begin
      @(posedge i_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= w;
      i_wb_adr <= a;
      i_wb_dat <= d;
      i_wb_sel <= 4'hf;
      n = 0;
      do begin
        @(posedge i_clk);
        n++;
      end while (o_wb_ack !== 1'b1 && n < 50);
      if (n == 50) failures++;
      if (n == 50) end_sim;
      r = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
    end
  endtask
  task push(input [7:0] v);
    if (v == 8'h7e || v == 8'h7d) begin
      expq.push_back(8'h7d);
      expq.push_back(v ^ 8'h20);
    end else expq.push_back(v);
  endtask
  task automatic pkt(input int n, input [31:0] m);
    logic [31:0] c;
    int j;
    begin
      c = 32'hffff_ffff;
      b.delete();
      for (j = 0; j < n; j++) begin
        rnd = lfsr(rnd);
        b.push_back(j == 0 ? 8'h7e : j == 1 ? 8'h7d : rnd);
        push(b[j]);
        c = crcb(c, b[j], m[1]);
      end
      if (!m[2]) c = ~c;
      if (m[0]) for (j = m[1] ? 3 : 1; j >= 0; j--) push(c[8*j+:8]);
      for (j = 0; j < n; j += 2)
        u_ptf_pkt_src.send({b[j], j + 1 < n ? b[j+1] : 8'h00}, j == 0, j + 2 >= n, j + 1 >= n);
    end
  endtask
  task automatic drain;
    int n;
    begin
      n = 0;
      while (expq.size() != 0 && n < 5000) begin
        @(posedge i_clk);
        n++;
      end
      if (n == 5000) failures++;
      if (n == 5000) end_sim;
      repeat (100) @(posedge i_clk);
    end
  endtask
  // =====================================================
  // line clock and random overhead gaps
  always @(posedge i_clk) begin
    lc <= lc + 3'h1;
    if (run) i_line_side_clock <= lc[2];
    if (lc == 3'h1) begin
      gr = lfsr(gr);
      i_overhead_gap <= run && gr[1:0] == 2'b00;
    end
  end
  // =====================================================
  // monitor: descramble, skip fill flags, compare with the oldest note
  always @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n) ds = '1;
    else if (o_line_valid) begin
      for (k = 7; k >= 0; k--) begin
        // a bypassed scrambler still advances on the bits it would have sent
        x[k] = o_line_data[k] ^ (son & ds[42]);
        ds = {ds[41:0], o_line_data[k] ^ (~son & ds[42])};
      end
      if (x == 8'h7e && !(expq.size() != 0 && expq[0] == 8'h7e)) gap++;
      else if (expq.size() == 0) chk(32'(x), 32'h7e);
      else begin
        chk(32'(x), 32'(expq.pop_front()));
        if (gap != 0) lastgap = gap;
        gap = 0;
      end
    end
  // =====================================================
  // main sequence
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    run <= 1'b1;
    repeat (8) @(posedge i_clk);
    wb(8'h00, 0, 32'h0, q);
    chk(q, 32'h0000_0009);
    wb(8'h04, 0, 32'h0, q);
    chk(q, 32'h0080_00e0);
    wb(8'h08, 0, 32'h0, q);
    chk(q & 32'h7_0000, 32'h4_0000);
    wb(8'h40, 1, 32'hffff_ffff, q);
    wb(8'h40, 0, 32'h0, q);
    chk(q, 32'h0);
    $display("test registers done");
    for (i = 0; i < 6; i++) begin
      wb(8'h00, 1, modes[i], q);
      son <= modes[i][3];
      pkt(18 + i, modes[i]);
      pkt(20, modes[i]);
      drain;
      chk(lastgap, modes[i][15:8] + 32'h1);
    end
    $display("test modes done");
    wb(8'h00, 1, 32'h09, q);
    son <= 1'b1;
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      b[i] = rnd;
      push(b[i]);
    end
    expq.push_back(8'h7d);
    expq.push_back(8'h7e);
    u_ptf_pkt_src.send({b[0], b[1]}, 1, 0, 0);
    u_ptf_pkt_src.send({b[2], b[3]}, 0, 0, 0);
    repeat (200) @(posedge i_clk);
    u_ptf_pkt_src.send(16'h7e7d, 0, 1, 0);
    pkt(6, 32'h09);
    drain;
    wb(8'h08, 0, 32'h0, q);
    chk(q & 32'h2_0000, 32'h2_0000);
    wb(8'h0c, 0, 32'h0, q);
    chk(q, 32'h0001_000d);
    wb(8'h08, 1, 32'h2_0000, q);
    $display("test abort done");
    // line held still so the fifo overfills on purpose
    run <= 1'b0;
    for (i = 0; i < 140; i++) u_ptf_pkt_src.send(16'h1234, i == 0, i == 139, 0);
    wb(8'h08, 0, 32'h0, q);
    chk(q & 32'h7_01ff, 32'h1_0100);
    chk(32'(o_transmit_packet_available), 32'h0);
    $display("test overrun done");
    end_sim;
  end
endmodule
